// ---- src/dma_control_status.sv ----
/*
 * dma control and status register with off-chip write hold-off and interrupt status.
 * assumes the sequencer pulses repeat_overflow and end_of_op for one cycle and
 * holds xram_write_req until xram_write_go is seen; register port is one-cycle strobes.
 * reads of unmapped indices return zero and writes to them are dropped.
 */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module dma_control_status
    import dma_csr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              repeat_overflow,
    input  wire logic              end_of_op,
    input  wire logic              xram_write_req,
    input  wire logic              xram_write_done,
    output logic                   xram_write_go,
    output logic                   irq
);
    logic              halt_q;
    logic              ovf_ie_q;
    logic              ovf_flag_q;
    logic              eop_ie_q;
    logic              eop_flag_q;
    logic              busy_q;
    logic              stat_ovf_q;
    logic              stat_eop_q;
    logic [1:0]        stat_clr;
    logic [1:0]        mask_q;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;
    logic              ovf_irq;
    logic              eop_irq;
    logic              go_d;
    logic              irq_d;
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] rd_d;

    assign wr_ctrl  = reg_write && reg_addr == CTRL_OFFSET;
    assign wr_stat  = reg_write && reg_addr == IRQ_STAT_OFFSET;
    assign wr_mask  = reg_write && reg_addr == IRQ_MASK_OFFSET;
    assign stat_clr = wr_stat ? reg_wdata[1:0] : 2'h0;

    // halt only gates new grants, so a write already granted still finishes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            halt_q <= CTRL_RESET[BIT_HALT];
        else if (clk_en && wr_ctrl)
            halt_q <= reg_wdata[BIT_HALT];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ovf_ie_q <= CTRL_RESET[BIT_OVF_IE];
        else if (clk_en && wr_ctrl)
            ovf_ie_q <= reg_wdata[BIT_OVF_IE];
    end

    // sticky: only a written zero clears it; an overflow in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ovf_flag_q <= CTRL_RESET[BIT_OVF_FLAG];
        else if (clk_en)
        begin
            if (repeat_overflow)
                ovf_flag_q <= 1'b1;
            else if (wr_ctrl && !reg_wdata[BIT_OVF_FLAG])
                ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            eop_ie_q <= CTRL_RESET[BIT_EOP_IE];
        else if (clk_en && wr_ctrl)
            eop_ie_q <= reg_wdata[BIT_EOP_IE];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            eop_flag_q <= CTRL_RESET[BIT_EOP_FLAG];
        else if (clk_en)
        begin
            if (end_of_op)
                eop_flag_q <= 1'b1;
            else if (wr_ctrl && !reg_wdata[BIT_EOP_FLAG])
                eop_flag_q <= 1'b0;
        end
    end

    // write one to clear; a new event in the clearing cycle keeps the bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stat_ovf_q <= STAT_RESET[IRQ_OVF];
        else if (clk_en)
        begin
            if (repeat_overflow)
                stat_ovf_q <= 1'b1;
            else if (stat_clr[IRQ_OVF])
                stat_ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stat_eop_q <= STAT_RESET[IRQ_EOP];
        else if (clk_en)
        begin
            if (end_of_op)
                stat_eop_q <= 1'b1;
            else if (stat_clr[IRQ_EOP])
                stat_eop_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= MASK_RESET;
        else if (clk_en && wr_mask)
            mask_q <= reg_wdata[1:0];
    end

    // each enable bit gates its flag and its masked status alike, so a cleared enable
    // silences that event on every path into the line
    always_comb
    begin
        ovf_irq = ovf_ie_q
                  && (ovf_flag_q || (stat_ovf_q && mask_q[IRQ_OVF]));
        eop_irq = eop_ie_q
                  && (eop_flag_q || (stat_eop_q && mask_q[IRQ_EOP]));
        irq_d   = ovf_irq || eop_irq;
    end

    // one grant per write: busy blocks a second grant until the write is done
    always_comb
    begin
        go_d = xram_write_req && !halt_q && !busy_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_q <= 1'b0;
        else if (clk_en)
        begin
            if (go_d)
                busy_q <= 1'b1;
            else if (xram_write_done)
                busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            xram_write_go <= 1'b0;
        else if (clk_en)
            xram_write_go <= go_d;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else if (clk_en)
            irq <= irq_d;
    end

    // bits 5:4 are reserved and read zero
    always_comb
    begin
        ctrl_view               = '0;
        ctrl_view[BIT_HALT]     = halt_q;
        ctrl_view[BIT_BUSY]     = busy_q;
        ctrl_view[BIT_OVF_IE]   = ovf_ie_q;
        ctrl_view[BIT_OVF_FLAG] = ovf_flag_q;
        ctrl_view[BIT_EOP_IE]   = eop_ie_q;
        ctrl_view[BIT_EOP_FLAG] = eop_flag_q;
    end

    always_comb
    begin
        rd_d = '0;
        unique case (reg_addr)
            CTRL_OFFSET:     rd_d = ctrl_view;
            IRQ_STAT_OFFSET: rd_d = {6'h00, stat_ovf_q, stat_eop_q};
            IRQ_MASK_OFFSET: rd_d = {6'h00, mask_q};
            default:         rd_d = '0;
        endcase
    end

    // read data stand for one cycle only, then return to zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (clk_en)
            reg_rdata <= reg_read ? rd_d : '0;
    end
endmodule

// ---- src/dma_csr_pkg.sv ----
/*
 * package for the dma control and status register block: offsets, field positions,
 * reset values.
 * assumes a byte-wide register port; all registers sit at small word indices.
 */
package dma_csr_pkg;
    localparam int         ADDR_W          = 4;
    localparam int         DATA_W          = 8;
    localparam logic [3:0] CTRL_OFFSET     = 4'h0;
    localparam logic [3:0] IRQ_STAT_OFFSET = 4'h1;
    localparam logic [3:0] IRQ_MASK_OFFSET = 4'h2;
    localparam int         BIT_HALT        = 7;
    localparam int         BIT_BUSY        = 6;
    localparam int         BIT_OVF_IE      = 3;
    localparam int         BIT_OVF_FLAG    = 2;
    localparam int         BIT_EOP_IE      = 1;
    localparam int         BIT_EOP_FLAG    = 0;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [1:0] STAT_RESET      = 2'h0;
    localparam logic [1:0] MASK_RESET      = 2'h0;
    localparam int         IRQ_OVF         = 1;
    localparam int         IRQ_EOP         = 0;
endpackage

// ---- test/dma_control_status_properties.sv ----
/* port-level checker for dma_control_status.
   assumes nothing moves while clk_en is low; helpers mirror the control and mask writes. */
`timescale 1ns/1ns
module dma_control_status_chk
    import dma_csr_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              repeat_overflow,
    input wire logic              xram_write_go,
    input wire logic              irq
);
    logic       flag_q, ie_q, halt_q, wc, rc;
    logic [1:0] mask_q;
    assign wc = reg_write && reg_addr == CTRL_OFFSET;
    assign rc = reg_read && reg_addr == CTRL_OFFSET;
    // an overflow in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {flag_q, ie_q, halt_q, mask_q} <= '0;
        else if (clk_en)
        begin
            flag_q <= repeat_overflow | (flag_q & ~(wc & ~reg_wdata[BIT_OVF_FLAG]));
            if (wc) {halt_q, ie_q} <= {reg_wdata[BIT_HALT], reg_wdata[BIT_OVF_IE]};
            if (reg_write && reg_addr == IRQ_MASK_OFFSET) mask_q <= reg_wdata[1:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_flag_reads_set:
        assert property (rc && flag_q |=> reg_rdata[BIT_OVF_FLAG]) else $error("flag low");
    a_flag_reads_clear:
        assert property (rc && !flag_q |=> !reg_rdata[BIT_OVF_FLAG]) else $error("flag high");
    a_irq_when_enabled:
        assert property (flag_q && ie_q |=> irq) else $error("irq missing");
    a_irq_when_disabled:
        assert property (!ie_q && mask_q == 2'h0 |=> !irq) else $error("irq unexpected");
    a_halt_blocks_go:
        assert property ($past(halt_q) |-> !xram_write_go) else $error("go during halt");
    a_go_single_pulse:
        assert property (xram_write_go |=> !xram_write_go) else $error("go too long");
endmodule
bind dma_control_status dma_control_status_chk u_chk (.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .repeat_overflow, .xram_write_go, .irq);

// ---- test/test_dma_control_status.sv ----
/* register-level bench for dma_control_status.
   drives every input itself; clk_en is lowered once to check the freeze. */
`timescale 1ns/1ns
module test_dma_control_status
    import dma_csr_pkg::*;
;
    logic       clk = 0, rst_n = 0, clk_en = 1, reg_write = 0, reg_read = 0, xram_write_go, irq;
    logic       repeat_overflow = 0, end_of_op = 0, xram_write_req = 0, xram_write_done = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    int         errors = 0, checks_done = 0, n;
    dma_control_status u_dut (.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .repeat_overflow, .end_of_op, .xram_write_req,
        .xram_write_done, .xram_write_go, .irq);
    always #10 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        cmp("rdata", reg_rdata, e);
    endtask
    // about 85 cycles of tests, so 5000 cycles means a hang
    initial
    begin
        #100000;
        errors++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(CTRL_OFFSET, CTRL_RESET);
        @(posedge clk);
        repeat_overflow <= 1'b1;
        @(posedge clk);
        repeat_overflow <= 1'b0;
        rd(CTRL_OFFSET, 8'h04);
        cmp("irq", {7'h0, irq}, 8'h00);
        wr(CTRL_OFFSET, 8'h04);
        rd(CTRL_OFFSET, 8'h04);
        $display("test overflow flag done");
        wr(CTRL_OFFSET, 8'h0C);
        cmp("irq", {7'h0, irq}, 8'h01);
        wr(CTRL_OFFSET, 8'h00);
        rd(CTRL_OFFSET, 8'h00);
        wr(IRQ_MASK_OFFSET, 8'h02);
        cmp("irq", {7'h0, irq}, 8'h00);
        wr(CTRL_OFFSET, 8'h08);
        cmp("irq", {7'h0, irq}, 8'h01);
        wr(IRQ_STAT_OFFSET, 8'h02);
        rd(IRQ_STAT_OFFSET, 8'h00);
        cmp("irq", {7'h0, irq}, 8'h00);
        rd(4'hF, 8'h00);
        $display("test interrupt done");
        wr(CTRL_OFFSET, 8'hF0);
        rd(CTRL_OFFSET, 8'h80);
        @(posedge clk);
        xram_write_req <= 1'b1;
        for (n = 0; n < 6; n++) @(negedge clk) cmp("go", {7'h0, xram_write_go}, 8'h00);
        wr(CTRL_OFFSET, 8'h00);
        for (n = 0; n < 8 && xram_write_go !== 1'b1; n++) @(negedge clk);
        cmp("go", {7'h0, xram_write_go}, 8'h01);
        @(posedge clk);
        xram_write_req <= 1'b0;
        rd(CTRL_OFFSET, 8'h40);
        @(posedge clk);
        xram_write_done <= 1'b1;
        @(posedge clk);
        xram_write_done <= 1'b0;
        rd(CTRL_OFFSET, 8'h00);
        $display("test halt done");
        @(posedge clk);
        clk_en <= 1'b0;
        repeat_overflow <= 1'b1;
        @(posedge clk);
        repeat_overflow <= 1'b0;
        clk_en <= 1'b1;
        rd(CTRL_OFFSET, 8'h00);
        rd(IRQ_STAT_OFFSET, 8'h00);
        $display("test clock enable done");
        @(posedge clk);
        end_of_op <= 1'b1;
        @(posedge clk);
        end_of_op <= 1'b0;
        rd(CTRL_OFFSET, 8'h01);
        rd(IRQ_STAT_OFFSET, 8'h01);
        wr(CTRL_OFFSET, 8'h03);
        cmp("irq", {7'h0, irq}, 8'h01);
        wr(CTRL_OFFSET, 8'h00);
        rd(CTRL_OFFSET, 8'h00);
        cmp("irq", {7'h0, irq}, 8'h00);
        $display("test end of operation done");
        stop_test();
    end
endmodule
